/* File: verilog/chgcfg_regs.sv */
// Power-on configuration and charge current registers of the charger.
// Assumes the I2C slave engine has matched the slave address and hands
// over one decoded register access per one-cycle strobe.
`timescale 1ns/100ps

// Function
// R1 - Reset loads 0x1B and 0x60
// R2 - Writing bit 7 restores all defaults
// R3 - Soft reset touches registers, not device mode
// R4 - Bit 6 restarts watchdog; host spaces kicks
// R5 - Bit 5 boost enable; bit 0 limit
// R6 - Boost enable overrides charge enable
// R7 - Bit 4 enables charging, default one
// R8 - Minimum system voltage 3.0 V plus code
// R9 - Current register bit 7 reads zero
// R10 - Fast current 512 mA plus 64 mA steps
// R11 - Host keeps fast current at most 2048 mA
// R12 - Bit 1 selects boost cold threshold
// R13 - Bit 0 forces 20% and 50% currents
// R14 - Registers at slave address 6BH
// R15 - Reset and kick bits self clear
module chgcfg_regs (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_srst,
  input  wire chgcfg_pkg::chgcfg_req_t  i_req,
  input  wire logic                     i_cold_trip,
  output logic [7:0]                    o_rdata,
  output logic                          o_ack,
  output logic                          o_wdog_kick,
  output chgcfg_pkg::chgcfg_ctl_t       o_ctl
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_SRST = 2'b10
  } chgcfg_st_t;

  typedef struct packed {
    chgcfg_st_t              st;
    logic [7:0]              pwr_cfg;
    logic [7:0]              chg_cur;
    logic [7:0]              rdata;
    logic                    ack;
    logic                    kick;
    chgcfg_pkg::chgcfg_ctl_t ctl;
  } chgcfg_state_t;

  chgcfg_state_t           state_reg;
  chgcfg_state_t           state_next;
  chgcfg_pkg::chgcfg_ctl_t ctl_dec;

  // Only the two modelled registers answer
  function automatic logic hit(input logic [7:0] a);
    hit = (a == chgcfg_pkg::ADDR_PWR_CFG) ||
          (a == chgcfg_pkg::ADDR_CHG_CUR); // R14
  endfunction : hit

  // Settings decode from the values now held
  chgcfg_decode u_dec (
    .i_pwr_cfg   (state_reg.pwr_cfg),
    .i_chg_cur   (state_reg.chg_cur),
    .i_cold_trip (i_cold_trip),
    .o_ctl       (ctl_dec)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next       = state_reg;
    state_next.ack   = 1'b0;
    state_next.kick  = 1'b0;
    state_next.ctl   = ctl_dec;
    // Kick bit stored only one cycle, so reads from the second cycle after the write see it clear
    state_next.pwr_cfg[chgcfg_pkg::BIT_WDOG_KICK] = 1'b0; // R15
    case (state_reg.st)
      ST_RUN: begin
        if (i_req.wr && hit(i_req.addr)) begin
          state_next.ack = 1'b1;
          if (i_req.addr == chgcfg_pkg::ADDR_PWR_CFG) begin
            // Kick is a pulse; spacing is the host's duty
            state_next.kick = i_req.wdata[chgcfg_pkg::BIT_WDOG_KICK]; // R4
            if (i_req.wdata[chgcfg_pkg::BIT_REG_RESET]) begin
              // Old settings stand one cycle: the written byte never
              // reaches the decoder, so no transient boost request
              state_next.st = ST_SRST; // R2
            end else begin
              state_next.pwr_cfg = i_req.wdata;
            end
          end else begin
            state_next.chg_cur = i_req.wdata;
            // Reserved bit never holds a one
            state_next.chg_cur[chgcfg_pkg::BIT_CUR_RSVD] = 1'b0; // R9
          end
        end else if (i_req.rd && hit(i_req.addr)) begin
          state_next.ack   = 1'b1;
          state_next.rdata = (i_req.addr == chgcfg_pkg::ADDR_PWR_CFG) ?
                             state_reg.pwr_cfg : state_reg.chg_cur;
        end
      end
      ST_SRST: begin
        // Registers only; analog mode is left to its own logic
        state_next.pwr_cfg = chgcfg_pkg::PWR_CFG_RST; // R2 R3 R15
        state_next.chg_cur = chgcfg_pkg::CHG_CUR_RST; // R2
        state_next.st      = ST_RUN;
      end
      default: begin
        state_next.st = ST_RUN;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_reg.st      <= ST_RUN;
      state_reg.pwr_cfg <= chgcfg_pkg::PWR_CFG_RST; // R1
      state_reg.chg_cur <= chgcfg_pkg::CHG_CUR_RST; // R1
      state_reg.rdata   <= 8'h00;
      state_reg.ack     <= 1'b0;
      state_reg.kick    <= 1'b0;
      state_reg.ctl     <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata     = state_reg.rdata;
  assign o_ack       = state_reg.ack;
  assign o_wdog_kick = state_reg.kick;
  assign o_ctl       = state_reg.ctl;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_rst_vals;
    @(posedge i_ref_clk) i_srst |=>
      state_reg.pwr_cfg == 8'h1B && state_reg.chg_cur == 8'h60 &&
      !o_ack && !o_wdog_kick;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad reset"); // R1

  property p_soft_rst;
    @(posedge i_ref_clk) disable iff (i_srst)
      (state_reg.st == ST_RUN && i_req.wr &&
       i_req.addr == 8'h01 && i_req.wdata[7]) |-> ##2
      (state_reg.pwr_cfg == 8'h1B && state_reg.chg_cur == 8'h60);
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("no defaults"); // R2

  property p_kick;
    @(posedge i_ref_clk) disable iff (i_srst)
      (state_reg.st == ST_RUN && i_req.wr && i_req.addr == 8'h01)
      |=> o_wdog_kick == $past(i_req.wdata[6]);
  endproperty
  a_kick: assert property (p_kick) else $error("kick wrong"); // R4

  property p_prio;
    @(posedge i_ref_clk) disable iff (i_srst)
      state_reg.pwr_cfg[5] |=> !o_ctl.charge_allow;
  endproperty
  a_prio: assert property (p_prio) else $error("charge in boost"); // R6

  property p_chg;
    @(posedge i_ref_clk) disable iff (i_srst)
      (state_reg.pwr_cfg[5:4] == 2'b01) |=> o_ctl.charge_allow;
  endproperty
  a_chg: assert property (p_chg) else $error("charge off"); // R7

  property p_sysmin;
    @(posedge i_ref_clk) disable iff (i_srst)
      (state_reg.pwr_cfg[3:1] == 3'h5) |=> o_ctl.sysmin_cv == 12'h15E;
  endproperty
  a_sysmin: assert property (p_sysmin) else $error("sysmin"); // R8

  property p_rsvd;
    @(posedge i_ref_clk) disable iff (i_srst) !state_reg.chg_cur[7];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved set"); // R9

  property p_fast_cur;
    @(posedge i_ref_clk) disable iff (i_srst)
      (state_reg.chg_cur[6:2] == 5'h18) |=> o_ctl.fast_cur_ma == 12'h800;
  endproperty
  a_fast_cur: assert property (p_fast_cur) else $error("fast cur"); // R10

  property p_force;
    @(posedge i_ref_clk) disable iff (i_srst)
      state_reg.chg_cur[0] |=> o_ctl.fast_pct == 8'h14 &&
                               o_ctl.pre_pct == 8'h32;
  endproperty
  a_force: assert property (p_force) else $error("force pct"); // R13

  property p_self_clr;
    @(posedge i_ref_clk) disable iff (i_srst)
      state_reg.pwr_cfg[6] |=> !state_reg.pwr_cfg[6];
  endproperty
  a_self_clr: assert property (p_self_clr) else $error("kick stuck"); // R15

  // Reset request bit is acted on, never stored
  property p_rst_bit;
    @(posedge i_ref_clk) disable iff (i_srst)
      !state_reg.pwr_cfg[chgcfg_pkg::BIT_REG_RESET];
  endproperty
  a_rst_bit: assert property (p_rst_bit) else $error("reset bit"); // R15

  // Cold trip at the selected level drops boost on the next edge
  property p_cold_drop;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_cold_trip |=> !o_ctl.boost_on;
  endproperty
  a_cold_drop: assert property (p_cold_drop) else $error("cold boost"); // R12

  property p_boost_on;
    @(posedge i_ref_clk) disable iff (i_srst)
      (state_reg.pwr_cfg[5] && !i_cold_trip) |=> o_ctl.boost_on;
  endproperty
  a_boost_on: assert property (p_boost_on) else $error("boost off"); // R5

  property p_lim;
    @(posedge i_ref_clk) disable iff (i_srst)
      1'b1 |=> o_ctl.boost_lim_hi == $past(state_reg.pwr_cfg[0]);
  endproperty
  a_lim: assert property (p_lim) else $error("boost limit"); // R5

  // An answer only ever follows a strobe at a mapped place
  property p_ack_map;
    @(posedge i_ref_clk) disable iff (i_srst)
      o_ack |-> $past((i_req.wr || i_req.rd) &&
        (i_req.addr == chgcfg_pkg::ADDR_PWR_CFG ||
         i_req.addr == chgcfg_pkg::ADDR_CHG_CUR));
  endproperty
  a_ack_map: assert property (p_ack_map) else $error("stray ack"); // R14

  c_soft: cover property (@(posedge i_ref_clk) state_reg.st == ST_SRST);
  c_kick: cover property (@(posedge i_ref_clk) o_wdog_kick);
  c_boost: cover property (@(posedge i_ref_clk) o_ctl.boost_on);
  c_rd: cover property (@(posedge i_ref_clk) o_ack && !i_req.wr);

endmodule : chgcfg_regs

/* File: verilog/chgcfg_pkg.sv */
// Package for the charger power-on and charge current configuration bank.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package chgcfg_pkg;

  // ---------------------------------------------------------------
  // Register addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR    = 7'h6B;
  localparam logic [7:0] ADDR_PWR_CFG  = 8'h01;
  localparam logic [7:0] ADDR_CHG_CUR  = 8'h02;
  localparam logic [7:0] PWR_CFG_RST   = 8'h1B;
  localparam logic [7:0] CHG_CUR_RST   = 8'h60;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_REG_RESET  = 7;
  localparam int BIT_WDOG_KICK  = 6;
  localparam int BIT_BOOST_EN   = 5;
  localparam int BIT_CHG_EN     = 4;
  localparam int BIT_SYSMIN_HI  = 3;
  localparam int BIT_SYSMIN_LO  = 1;
  localparam int BIT_BOOST_LIM  = 0;
  localparam int BIT_CUR_RSVD   = 7;
  localparam int BIT_FAST_HI    = 6;
  localparam int BIT_FAST_LO    = 2;
  localparam int BIT_COLD_SEL   = 1;
  localparam int BIT_FORCE_RED  = 0;

  // ---------------------------------------------------------------
  // Decode constants
  // ---------------------------------------------------------------
  localparam logic [11:0] SYSMIN_BASE_CV   = 12'h12C; // 3.0 V in 10 mV
  localparam logic [11:0] SYSMIN_STEP_CV   = 12'h00A; // 0.1 V in 10 mV
  localparam logic [11:0] FAST_CUR_BASE_MA = 12'h200; // 512 mA
  localparam logic [11:0] FAST_CUR_STEP_MA = 12'h040; // 64 mA
  localparam logic [11:0] FAST_CUR_MAX_MA  = 12'h800; // 2048 mA
  localparam logic [11:0] BOOST_LIM_LO_MA  = 12'h3E8; // 1 A
  localparam logic [11:0] BOOST_LIM_HI_MA  = 12'h5DC; // 1.5 A
  localparam logic [7:0]  COLD_FIRST_PCT   = 8'h4C;   // 76 %
  localparam logic [7:0]  COLD_SECOND_PCT  = 8'h4F;   // 79 %
  localparam logic [7:0]  FAST_RED_PCT     = 8'h14;   // 20 %
  localparam logic [7:0]  PRE_RED_PCT      = 8'h32;   // 50 %
  localparam logic [7:0]  FULL_PCT         = 8'h64;   // 100 %

  // Least spacing of watchdog kicks, host side
  localparam int WDOG_GAP_US     = 20;
  localparam int CLK_MHZ         = 100;
  localparam int WDOG_GAP_CYCLES = WDOG_GAP_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } chgcfg_req_t;

  typedef struct packed {
    logic        charge_allow;
    logic        boost_on;
    logic        boost_lim_hi;
    logic [11:0] sysmin_cv;
    logic [11:0] fast_cur_ma;
    logic [7:0]  cold_pct;
    logic [7:0]  fast_pct;
    logic [7:0]  pre_pct;
  } chgcfg_ctl_t;

endpackage : chgcfg_pkg

/* File: verilog/chgcfg_decode.sv */
// Decoder from configuration register values to analog control settings.
// Assumes the caller registers the outputs it drives out of the block.
`timescale 1ns/100ps
module chgcfg_decode (
  input  wire logic [7:0]             i_pwr_cfg,
  input  wire logic [7:0]             i_chg_cur,
  input  wire logic                   i_cold_trip,
  output chgcfg_pkg::chgcfg_ctl_t     o_ctl
);

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  logic [2:0] sysmin_code;
  logic [4:0] fast_code;
  logic       boost;

  assign sysmin_code = i_pwr_cfg[chgcfg_pkg::BIT_SYSMIN_HI:
                                 chgcfg_pkg::BIT_SYSMIN_LO];
  assign fast_code   = i_chg_cur[chgcfg_pkg::BIT_FAST_HI:
                                 chgcfg_pkg::BIT_FAST_LO];
  // Cold trip at the selected level drops boost
  assign boost = i_pwr_cfg[chgcfg_pkg::BIT_BOOST_EN] & ~i_cold_trip; // R12

  // Outputs built from the fields
  always_comb begin
    o_ctl.boost_on     = boost; // R5
    // Boost request wins over charge enable, regardless of cold trip
    o_ctl.charge_allow = i_pwr_cfg[chgcfg_pkg::BIT_CHG_EN] &
                         ~i_pwr_cfg[chgcfg_pkg::BIT_BOOST_EN]; // R6 R7
    o_ctl.boost_lim_hi = i_pwr_cfg[chgcfg_pkg::BIT_BOOST_LIM]; // R5
    o_ctl.sysmin_cv    = chgcfg_pkg::SYSMIN_BASE_CV +
                         12'({9'h000, sysmin_code} *
                             chgcfg_pkg::SYSMIN_STEP_CV); // R8
    o_ctl.fast_cur_ma  = chgcfg_pkg::FAST_CUR_BASE_MA +
                         12'({7'h00, fast_code} *
                             chgcfg_pkg::FAST_CUR_STEP_MA); // R10
    o_ctl.cold_pct     = i_chg_cur[chgcfg_pkg::BIT_COLD_SEL] ?
                         chgcfg_pkg::COLD_SECOND_PCT :
                         chgcfg_pkg::COLD_FIRST_PCT; // R12
    o_ctl.fast_pct     = i_chg_cur[chgcfg_pkg::BIT_FORCE_RED] ?
                         chgcfg_pkg::FAST_RED_PCT :
                         chgcfg_pkg::FULL_PCT; // R13
    o_ctl.pre_pct      = i_chg_cur[chgcfg_pkg::BIT_FORCE_RED] ?
                         chgcfg_pkg::PRE_RED_PCT :
                         chgcfg_pkg::FULL_PCT; // R13
  end

endmodule : chgcfg_decode

/* File: sim/chgcfg_host_model.sv */
// Host-side model: hands the bank one decoded register access a cycle.
// Assumes the bank samples requests on the rising edge of i_ref_clk.
`timescale 1ns/100ps
module chgcfg_host_model (
  input  wire logic               i_ref_clk,
  output chgcfg_pkg::chgcfg_req_t o_req
);
  initial o_req = '0;

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  // Raise one request just after an edge; held until the next call
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (w && a == 8'h02 && v[6:2] > 5'h18) begin
      v[6:2] = 5'h18;
    end
    @(posedge i_ref_clk);
    #1;
    o_req = '{wr: w, rd: !w, addr: a, wdata: v};
  endtask : access

  // Released bus shows inverted stale data, never the last value
  task automatic idle();
    @(posedge i_ref_clk);
    #1;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~o_req.addr, wdata: ~o_req.wdata};
  endtask : idle
endmodule : chgcfg_host_model

/* File: sim/chgcfg_regs_tb_top.sv */
// Testbench for the charger configuration bank: queue-checked accesses.
// Assumes the host model drives requests; bench owns clock and reset.
`timescale 1ns/100ps
module chgcfg_regs_tb_top;
  logic                    i_ref_clk   = 1'b0;
  logic                    i_srst      = 1'b1;
  logic                    i_cold_trip = 1'b0;
  chgcfg_pkg::chgcfg_req_t i_req;
  logic [7:0]              o_rdata;
  logic                    o_ack;
  logic                    o_wdog_kick;
  chgcfg_pkg::chgcfg_ctl_t o_ctl;
  logic [8:0]              exp_q[$];
  logic [8:0]              e_w;
  logic [7:0]              pwr_m = 8'h1B;
  logic [7:0]              cur_m = 8'h60;
  int                      error_cnt = 0;
  int                      checked = 0;
  int                      kicks = 0;
  int                      cyc = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  chgcfg_host_model chgcfg_host_model_i (
    .i_ref_clk (i_ref_clk),
    .o_req     (i_req)
  );
  chgcfg_regs chgcfg_regs_i (
    .i_ref_clk   (i_ref_clk),
    .i_srst      (i_srst),
    .i_req       (i_req),
    .i_cold_trip (i_cold_trip),
    .o_rdata     (o_rdata),
    .o_ack       (o_ack),
    .o_wdog_kick (o_wdog_kick),
    .o_ctl       (o_ctl)
  );

  // ---------------------------------------------------------------
  // Checking and reporting
  // ---------------------------------------------------------------
  task automatic check(input string n, input logic [63:0] s,
                       input logic [63:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %0h seen %0h", n, e, s);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // Settled outputs sampled mid-cycle; each ack takes the oldest note
  always @(negedge i_ref_clk) begin
    if (o_wdog_kick === 1'b1) kicks++;
    if (o_ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("stray ack", 1, 0);
      end else begin
        e_w = exp_q.pop_front();
        if (e_w[8]) check("rdata", o_rdata, e_w[7:0]);
      end
    end
  end

  // Hang guard well above the expected run length
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Access tasks with expectation notes
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a inside {8'h01, 8'h02}) exp_q.push_back(9'h000);
    chgcfg_host_model_i.access(1'b1, a, d);
    if (a == 8'h01 && d[7]) begin
      pwr_m = 8'h1B;
      cur_m = 8'h60;
    end else if (a == 8'h01) pwr_m = d & 8'h3F;
    else if (a == 8'h02) cur_m = d & 8'h7F;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    if (a == 8'h01) exp_q.push_back({1'b1, pwr_m});
    else if (a == 8'h02) exp_q.push_back({1'b1, cur_m});
    chgcfg_host_model_i.access(1'b0, a, 8'h00);
  endtask : rd

  // Decoded controls worked out from the field weights
  function automatic chgcfg_pkg::chgcfg_ctl_t ctl_m(input logic [7:0] p,
      input logic [7:0] c, input logic t);
    ctl_m.charge_allow = p[4] & ~p[5];
    ctl_m.boost_on     = p[5] & ~t;
    ctl_m.boost_lim_hi = p[0];
    ctl_m.sysmin_cv    = 12'h12C + 12'(p[3:1]) * 12'h00A;
    ctl_m.fast_cur_ma  = 12'h200 + 12'(c[6:2]) * 12'h040;
    ctl_m.cold_pct     = c[1] ? 8'h4F : 8'h4C;
    ctl_m.fast_pct     = c[0] ? 8'h14 : 8'h64;
    ctl_m.pre_pct      = c[0] ? 8'h32 : 8'h64;
  endfunction : ctl_m

  task automatic idle_chk();
    chgcfg_host_model_i.idle();
    repeat (3) @(posedge i_ref_clk);
    #1;
    check("ctl", 64'(o_ctl), 64'(ctl_m(pwr_m, cur_m, i_cold_trip)));
  endtask : idle_chk

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(13));
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_srst = 1'b0;
    rd(8'h01);
    rd(8'h02);
    idle_chk();
    $display("test defaults done");
    // Back-to-back random fields; reserved bit always written as zero
    for (int k = 0; k < 40; k++) begin
      i_cold_trip = 1'($urandom);
      wr(8'h01, 8'($urandom) & 8'h3F);
      wr(8'h02, {1'b0, 5'($urandom_range(24, 0)), 2'($urandom)});
      rd(8'h01);
      rd(8'h02);
      idle_chk();
    end
    $display("test fields done");
    // Two kicks spaced by the host's least gap
    wr(8'h01, 8'h5B);
    chgcfg_host_model_i.idle();
    repeat (chgcfg_pkg::WDOG_GAP_CYCLES) @(posedge i_ref_clk);
    wr(8'h01, 8'h5B);
    // Kick bit has cleared by the second cycle after the write
    chgcfg_host_model_i.idle();
    rd(8'h01);
    idle_chk();
    check("kicks", 64'(kicks), 64'd2);
    $display("test kick done");
    // Soft reset; the access right after it is refused
    wr(8'h02, 8'h05);
    wr(8'h01, 8'hA4);
    chgcfg_host_model_i.access(1'b0, 8'h02, 8'h00);
    chgcfg_host_model_i.idle();
    rd(8'h01);
    rd(8'h02);
    idle_chk();
    $display("test soft reset done");
    // Unmapped places draw no ack and change nothing
    rd(8'h00);
    rd(8'h03);
    wr(8'h09, 8'hFF);
    rd(8'h01);
    idle_chk();
    $display("test unmapped done");
    // Reset in mid-run brings the defaults back
    wr(8'h02, 8'h2F);
    chgcfg_host_model_i.idle();
    i_srst = 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1;
    i_srst = 1'b0;
    pwr_m = 8'h1B;
    cur_m = 8'h60;
    rd(8'h01);
    rd(8'h02);
    idle_chk();
    $display("test mid reset done");
    // Every noted access must have drawn its answer
    check("pending notes", 64'(exp_q.size()), 64'h0);
    print_verdict();
  end
endmodule : chgcfg_regs_tb_top
